// *** rtl/i2crb_pkg.sv ***
package i2crb_pkg;

  // one-byte command codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_RDSR = 8'h05;

  // strap-selectable slave addresses (plain defaults)
  localparam logic [6:0] SLAVE_ADDR_0 = 7'h48;
  localparam logic [6:0] SLAVE_ADDR_1 = 7'h49;
  localparam logic [6:0] SLAVE_ADDR_2 = 7'h4A;

  localparam logic [15:0] BANK_SEL_ADDR = 16'h0000;
  localparam int unsigned BANK_SEL_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam logic [7:0] BUSY_READ_DATA = 8'hFF;
  localparam logic [1:0] FMT_DIRECT_EE = 2'h0;

  // timing; link side handles fast mode, 400 kbit/s at most
  localparam int unsigned REF_CLK_PERIOD_NS = 10;
  localparam int unsigned EE_BUSY_NS = 5000000;
  localparam int unsigned EE_BUSY_CYCLES = EE_BUSY_NS / REF_CLK_PERIOD_NS;
  localparam int unsigned BUSY_TMR_W = 20;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [2:0] {
    OP_CMD = 3'h0,
    OP_ADDR = 3'h1,
    OP_WRITE = 3'h2,
    OP_FETCH = 3'h3,
    OP_END = 3'h4
  } i2crb_op_e;

  typedef struct packed {
    i2crb_op_e kind;
    logic inc;
    logic [15:0] addr;
    logic [7:0] data;
  } i2crb_op_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic reg_wr;
    logic ee_wr;
    logic ee_commit;
  } i2crb_mem_req_s;

  typedef struct packed {
    logic test;
    logic [1:0] fmt;
    logic [1:0] addr_sel;
  } i2crb_strap_s;

  typedef enum logic [7:0] {
    LS_IDLE = 8'h01,
    LS_ADDR = 8'h02,
    LS_ADDR_ACK = 8'h04,
    LS_RX = 8'h08,
    LS_RX_ACK = 8'h10,
    LS_TX = 8'h20,
    LS_TX_ACK = 8'h40,
    LS_IGNORE = 8'h80
  } i2crb_link_e;

endpackage

// *** rtl/i2crb_bridge.sv ***
`timescale 1ns/1ps
// Contract
// R1: I2C fast-mode slave up to 400 kbit/s
// R2: first written byte is command, then address, data
// R3: commands 06 wren, 02 write, 03 read, 05 status
// R4: bank select 0 registers, 1 EEPROM
// R5: address 0 always holds bank select
// R6: master writes read command and address, then reads
// R7: fetch during ack, increment, shift out next
// R8: master ends read with NACK then STOP
// R9: intervening traffic makes reads repeat first byte
// R10: each data byte stored, then address increments
// R11: master ends writes with STOP
// R12: master sends write enable before EEPROM write
// R13: EEPROM write address wraps within 32-byte page
// R14: EEPROM busy up to 5 ms after write
// R15: status byte bit0 shows EEPROM busy
// R16: no Hs-mode, 10-bit, general call, ID
// R17: never stretch the clock line
// R18: slave address strap picks one of three
// R19: all bytes shifted MSB first
// R20: repeated START accepted in place of STOP-START
// R21: reset returns every register to default
// R22: soft reset spares interface, keeps latched straps
// R23: host waits 100 us and boot done flag
// R24: test strap with format 00 maps EEPROM directly
// R25: only own address acknowledged, rest ignored
module i2crb_bridge
  import i2crb_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES = i2crb_pkg::EE_BUSY_CYCLES,
  parameter logic [6:0] ADDR_0 = i2crb_pkg::SLAVE_ADDR_0,
  parameter logic [6:0] ADDR_1 = i2crb_pkg::SLAVE_ADDR_1,
  parameter logic [6:0] ADDR_2 = i2crb_pkg::SLAVE_ADDR_2
) (
  // clocks and resets
  input wire logic ref_clk_i,
  input wire logic link_clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // straps
  input wire logic test_strap_i,
  input wire logic [1:0] output_format_strap_i,
  input wire logic [1:0] addr_strap_i,
  // internal access
  output i2crb_pkg::i2crb_mem_req_s mem_req_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic [7:0] ee_rdata_i,
  // status
  output logic bank_select_o,
  output logic ee_busy_o,
  output logic direct_ee_mode_o,
  output logic boot_config_done_o,
  output logic [1:0] output_format_strap_o
);
  import i2crb_pkg::*;

  typedef struct packed {
    i2crb_strap_s strap_m;
    i2crb_strap_s strap_s;
    i2crb_strap_s strap;
    logic [1:0] strap_cnt;
    logic straps_done;
    logic req_m;
    logic req_s;
    logic req_p;
    logic ack_tgl;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] rdata;
    logic bank;
    logic wel;
    logic dirty;
    logic busy;
    logic [BUSY_TMR_W-1:0] timer;
    i2crb_mem_req_s out;
  } i2crb_core_s;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic ack_m;
    logic ack_s;
    logic [6:0] my_addr_m;
    logic [6:0] my_addr;
    i2crb_link_e st;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [1:0] bytecnt;
    logic [7:0] addr_hi;
    logic is_read;
    logic cmd_rd;
    logic armed;
    logic inc_mode;
    logic sda_oe;
    logic req_tgl;
    i2crb_op_s op;
  } i2crb_link_s;

  i2crb_core_s c_q, c_d;
  i2crb_link_s l_q, l_d;
  logic lrst_m, lrst_q;
  logic [6:0] strap_addr;
  logic ee_space;

  always_comb begin
    unique case (c_q.strap.addr_sel)
      2'h1: strap_addr = ADDR_1;
      2'h2: strap_addr = ADDR_2;
      default: strap_addr = ADDR_0; // [R18]
    endcase
  end

  // addresses above zero go to EEPROM when selected or in direct mode
  assign ee_space = c_q.bank | direct_ee_mode_o; // [R4] [R24]

  // ---------------- reference clock side ----------------
  always_comb begin
    c_d = c_q;
    c_d.out.reg_wr = 1'b0;
    c_d.out.ee_wr = 1'b0;
    c_d.out.ee_commit = 1'b0;
    c_d.out.addr = c_q.addr;
    c_d.strap_m = '{test: test_strap_i, fmt: output_format_strap_i, addr_sel: addr_strap_i};
    c_d.strap_s = c_q.strap_m;
    // straps caught once per hard reset, after the synchroniser fills
    if (!c_q.straps_done) begin
      if (c_q.strap_cnt == STRAP_SETTLE) begin
        c_d.strap = c_q.strap_s; // [R22] [R24]
        c_d.straps_done = 1'b1;
      end else begin
        c_d.strap_cnt = c_q.strap_cnt + 2'h1;
      end
    end
    c_d.req_m = l_q.req_tgl;
    c_d.req_s = c_q.req_m;
    c_d.req_p = c_q.req_s;
    if (c_q.busy) begin
      c_d.timer = c_q.timer + BUSY_TMR_W'(1);
      if (c_q.timer == BUSY_TMR_W'(BUSY_CYCLES - 1)) begin
        c_d.busy = 1'b0; // [R14]
      end
    end
    if (c_q.req_s != c_q.req_p) begin
      c_d.ack_tgl = c_q.req_s;
      unique case (l_q.op.kind)
        OP_CMD: begin
          c_d.cmd = l_q.op.data; // [R2]
          if (l_q.op.data == CMD_WREN) begin
            c_d.wel = 1'b1; // [R3] [R12]
          end
        end
        OP_ADDR: c_d.addr = l_q.op.addr;
        OP_WRITE: begin
          if (c_q.cmd == CMD_WRITE) begin
            c_d.out.wdata = l_q.op.data;
            if (c_q.addr == BANK_SEL_ADDR) begin
              c_d.bank = l_q.op.data[BANK_SEL_BIT]; // [R5]
              c_d.addr = c_q.addr + 16'h1;
            end else if (ee_space) begin
              if ((c_q.wel | direct_ee_mode_o) & ~c_q.busy) begin
                c_d.out.ee_wr = 1'b1;
                c_d.dirty = 1'b1;
              end
              c_d.addr = {c_q.addr[15:5], c_q.addr[4:0] + 5'h1}; // [R13]
            end else begin
              c_d.out.reg_wr = 1'b1; // [R10]
              c_d.addr = c_q.addr + 16'h1;
            end
          end
        end
        OP_FETCH: begin
          if (c_q.cmd == CMD_RDSR) begin
            c_d.rdata = 8'h00;
            c_d.rdata[STATUS_BUSY_BIT] = c_q.busy; // [R15]
          end else begin
            if (c_q.addr == BANK_SEL_ADDR) begin
              c_d.rdata = 8'h00;
              c_d.rdata[BANK_SEL_BIT] = c_q.bank; // [R5]
            end else if (ee_space) begin
              c_d.rdata = c_q.busy ? BUSY_READ_DATA : ee_rdata_i; // [R14]
            end else begin
              c_d.rdata = reg_rdata_i;
            end
            if (l_q.op.inc) begin
              c_d.addr = c_q.addr + 16'h1; // [R7]
            end
          end
        end
        default: begin
          // end of any transaction: a page with any written byte goes to the array
          if (c_q.dirty) begin
            c_d.out.ee_commit = 1'b1;
            c_d.dirty = 1'b0;
            c_d.wel = 1'b0;
            c_d.busy = 1'b1; // [R14]
            c_d.timer = '0;
          end
        end
      endcase
    end
    // soft reset leaves the host interface and latched straps alone
    if (soft_reset_i) begin
      c_d.bank = 1'b0; // [R22]
      c_d.wel = 1'b0;
      c_d.dirty = 1'b0;
      c_d.busy = 1'b0;
      c_d.timer = '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      c_q <= '0; // [R21]
    end else begin
      c_q <= c_d;
    end
  end

  // ---------------- link clock side ----------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lrst_m <= 1'b1;
      lrst_q <= 1'b1;
    end else begin
      lrst_m <= 1'b0;
      lrst_q <= lrst_m;
    end
  end

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic issue;
    i2crb_op_s nop;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    issue = 1'b0;
    nop = '0;
    l_d = l_q;
    l_d.scl_m = scl_i;
    l_d.scl_s = l_q.scl_m;
    l_d.scl_p = l_q.scl_s;
    l_d.sda_m = sda_i;
    l_d.sda_s = l_q.sda_m;
    l_d.sda_p = l_q.sda_s;
    l_d.ack_m = c_q.ack_tgl;
    l_d.ack_s = l_q.ack_m;
    l_d.my_addr_m = strap_addr;
    l_d.my_addr = l_q.my_addr_m;
    rise = l_q.scl_s & ~l_q.scl_p;
    fall = ~l_q.scl_s & l_q.scl_p;
    start = l_q.scl_s & l_q.scl_p & l_q.sda_p & ~l_q.sda_s;
    stop = l_q.scl_s & l_q.scl_p & ~l_q.sda_p & l_q.sda_s;
    if (start | stop) begin
      // a repeated start closes the frame just like a stop
      if (l_q.st != LS_IDLE) begin
        issue = 1'b1; // [R20]
        nop.kind = OP_END;
      end
      if (!l_q.is_read && l_q.cmd_rd && l_q.bytecnt == 2'h3) begin
        l_d.armed = 1'b1; // [R6]
      end
      l_d.cmd_rd = 1'b0;
      l_d.sda_oe = 1'b0;
      l_d.bitcnt = 4'h0;
      l_d.bytecnt = 2'h0;
      l_d.st = start ? LS_ADDR : LS_IDLE;
    end else begin
      unique case (l_q.st)
        LS_ADDR, LS_RX: begin
          if (rise) begin
            l_d.shreg = {l_q.shreg[6:0], l_q.sda_s}; // [R19]
            l_d.bitcnt = l_q.bitcnt + 4'h1;
          end else if (fall && l_q.bitcnt == 4'h8) begin
            l_d.bitcnt = 4'h0;
            if (l_q.st == LS_ADDR) begin
              l_d.armed = 1'b0; // [R9]
              // 7-bit compare only: no 10-bit or general call
              if (l_q.shreg[7:1] == l_q.my_addr) begin
                l_d.sda_oe = 1'b1; // [R25] [R16]
                l_d.is_read = l_q.shreg[0];
                l_d.inc_mode = l_q.armed;
                l_d.st = LS_ADDR_ACK;
                if (l_q.shreg[0]) begin
                  issue = 1'b1; // [R7]
                  nop.kind = OP_FETCH;
                  nop.inc = l_q.armed; // [R9]
                end
              end else begin
                l_d.st = LS_IGNORE; // [R25]
              end
            end else begin
              l_d.sda_oe = 1'b1;
              l_d.st = LS_RX_ACK;
              if (l_q.bytecnt != 2'h3) begin
                l_d.bytecnt = l_q.bytecnt + 2'h1;
              end
              issue = 1'b1; // [R2]
              nop.data = l_q.shreg;
              unique case (l_q.bytecnt)
                2'h0: begin
                  nop.kind = OP_CMD;
                  l_d.cmd_rd = (l_q.shreg == CMD_READ); // [R3]
                end
                2'h1: begin
                  issue = 1'b0;
                  l_d.addr_hi = l_q.shreg;
                end
                2'h2: begin
                  nop.kind = OP_ADDR;
                  nop.addr = {l_q.addr_hi, l_q.shreg};
                end
                default: nop.kind = OP_WRITE; // [R10]
              endcase
            end
          end
        end
        LS_ADDR_ACK, LS_TX_ACK: begin
          if (rise && l_q.st == LS_TX_ACK) begin
            if (l_q.sda_s) begin
              l_d.st = LS_IGNORE; // [R8]
            end else begin
              issue = 1'b1; // [R7]
              nop.kind = OP_FETCH;
              nop.inc = l_q.inc_mode; // [R9]
            end
          end else if (fall) begin
            l_d.bitcnt = 4'h0;
            if (l_q.is_read) begin
              l_d.shreg = c_q.rdata;
              l_d.sda_oe = ~c_q.rdata[7]; // [R19]
              l_d.st = LS_TX;
            end else begin
              l_d.sda_oe = 1'b0;
              l_d.st = LS_RX;
            end
          end
        end
        LS_RX_ACK: begin
          if (fall) begin
            l_d.sda_oe = 1'b0;
            l_d.st = LS_RX;
          end
        end
        LS_TX: begin
          if (fall) begin
            if (l_q.bitcnt == 4'h7) begin
              l_d.sda_oe = 1'b0;
              l_d.st = LS_TX_ACK;
            end else begin
              l_d.bitcnt = l_q.bitcnt + 4'h1;
              l_d.shreg = {l_q.shreg[6:0], 1'b0};
              l_d.sda_oe = ~l_q.shreg[6]; // [R7]
            end
          end
        end
        default: l_d.sda_oe = 1'b0;
      endcase
    end
    // ops are bytes apart on the wire, so one slot in flight is enough
    if (issue && (l_q.ack_s == l_q.req_tgl)) begin
      l_d.op = nop;
      l_d.req_tgl = ~l_q.req_tgl;
    end
  end

  always_ff @(posedge link_clk_i or posedge lrst_q) begin
    if (lrst_q) begin
      l_q <= '{st: LS_IDLE, scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
               sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0};
    end else begin
      l_q <= l_d; // [R1]
    end
  end

  // open drain data; clock line is input only, so never stretched
  assign sda_o = 1'b0; // [R17]
  assign sda_oe_o = l_q.sda_oe;
  assign mem_req_o = c_q.out;
  assign bank_select_o = c_q.bank;
  assign ee_busy_o = c_q.busy;
  assign direct_ee_mode_o = c_q.strap.test & (c_q.strap.fmt == FMT_DIRECT_EE); // [R24]
  assign boot_config_done_o = c_q.straps_done;
  assign output_format_strap_o = c_q.strap.fmt;

endmodule

// *** tb/i2crb_checker.sv ***
`timescale 1ns/1ps
module i2crb_checker
  import i2crb_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES = 200
) (
  // clocks and reset
  input wire logic ref_clk_i,
  input wire logic link_clk_i,
  input wire logic reset_i,
  // pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // access and status
  input wire i2crb_pkg::i2crb_mem_req_s mem_req_o,
  input wire logic bank_select_o,
  input wire logic ee_busy_o,
  input wire logic direct_ee_mode_o,
  input wire logic boot_config_done_o,
  input wire logic [1:0] output_format_strap_o
);
  logic [15:0] next_addr_q;
  logic [31:0] busy_cnt_q;
  logic [1:0] link_up_q;
  logic [3:0] rst_len_q = 4'h0;

  // eeprom steps wrap inside the 32-byte page
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      next_addr_q <= 16'h0000;
      busy_cnt_q <= 32'h0;
    end else begin
      if (mem_req_o.reg_wr) next_addr_q <= mem_req_o.addr + 16'h0001;
      if (mem_req_o.ee_wr) next_addr_q <= {mem_req_o.addr[15:5], mem_req_o.addr[4:0] + 5'h01};
      busy_cnt_q <= ee_busy_o ? busy_cnt_q + 32'h1 : 32'h0;
    end
  end

  // link flops leave reset two link edges late, so their first samples are unknown
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      link_up_q <= 2'h0;
    end else begin
      link_up_q <= {link_up_q[0], 1'b1};
    end
  end

  // reset reaches the link flops at once through lrst_q, without a link edge; still wait some core edges
  always_ff @(posedge ref_clk_i) begin
    if (!reset_i) begin
      rst_len_q <= 4'h0;
    end else if (rst_len_q != 4'hF) begin
      rst_len_q <= rst_len_q + 4'h1;
    end
  end

  a_sda_open_drain: assert property (@(posedge link_clk_i) disable iff (reset_i) !sda_o)
    else $error("sda driven high");
  a_sda_scl_low: assert property (
    @(posedge link_clk_i) disable iff (reset_i) link_up_q[1] && $changed(sda_oe_o) |-> !scl_i)
    else $error("sda moved while scl high");
  a_reset_quiet: assert property (
    @(posedge ref_clk_i) reset_i && rst_len_q > 4'h5 |-> !sda_oe_o && !ee_busy_o && !bank_select_o && !mem_req_o.reg_wr)
    else $error("outputs active in reset");
  a_addr_step: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (mem_req_o.reg_wr || mem_req_o.ee_wr) |=> ##[0:7] mem_req_o.addr == next_addr_q)
    else $error("address did not step");
  a_busy_on_commit: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) mem_req_o.ee_commit |-> ##[1:4] ee_busy_o)
    else $error("no busy after commit");
  a_busy_bounded: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) busy_cnt_q <= BUSY_CYCLES)
    else $error("busy too long");
  a_no_ee_busy: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) mem_req_o.ee_wr |-> !ee_busy_o)
    else $error("eeprom write while busy");
  a_ee_bank: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) mem_req_o.ee_wr |-> bank_select_o || direct_ee_mode_o)
    else $error("eeprom write outside eeprom bank");
  a_reg_bank: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    mem_req_o.reg_wr && mem_req_o.addr != BANK_SEL_ADDR |-> !bank_select_o && !direct_ee_mode_o)
    else $error("register write outside register bank");
  a_straps_stable: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    $past(boot_config_done_o) && boot_config_done_o |-> $stable(output_format_strap_o))
    else $error("latched strap moved");
endmodule

bind i2crb_bridge i2crb_checker #(.BUSY_CYCLES(BUSY_CYCLES)) u_checker (
  .ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .mem_req_o(mem_req_o), .bank_select_o(bank_select_o), .ee_busy_o(ee_busy_o),
  .direct_ee_mode_o(direct_ee_mode_o), .boot_config_done_o(boot_config_done_o),
  .output_format_strap_o(output_format_strap_o));

// *** tb/i2crb_master.sv ***
`timescale 1ns/1ps
module i2crb_master (
  // clock
  input wire logic clk_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // quarter bit: 2.52 us per bit keeps inside fast mode
  task automatic q();
    repeat (63) @(negedge clk_i);
  endtask

  // also serves as repeated start when scl is low
  task automatic start();
    q();
    sda_low_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b0;
  endtask

  task automatic stop();
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b0;
    // bus free time; the slave needs a few link cycles to see the stop
    q();
  endtask

  task automatic bit_x(input logic b, output logic r);
    q();
    sda_low_o = !b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    q();
    scl_o = 1'b0;
  endtask

  // ack_in high leaves the ack slot released
  task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(ack_in, ack);
  endtask
endmodule

// *** tb/i2crb_bridge_tb.sv ***
`timescale 1ns/1ps
module i2crb_bridge_tb;
  import i2crb_pkg::*;
  localparam int unsigned BUSY = 12000;
  logic ref_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic soft_reset_i = 1'b0;
  logic test_strap = 1'b0;
  logic [1:0] fmt_strap = 2'h1;
  logic [1:0] addr_strap = 2'h1;
  logic scl, m_low, sda_o, sda_oe_o, bank, busy, direct, done;
  logic [1:0] fmt_q;
  i2crb_mem_req_s mem_req;
  logic [7:0] regs [256];
  logic [7:0] ee [256];
  int fails = 0;
  int cmp_count = 0;
  wire sda = !(m_low || sda_oe_o);

  always #5 ref_clk_i = ~ref_clk_i;
  // offset keeps link edges off the core edges
  always begin
    #37 link_clk_i = ~link_clk_i;
    #3;
  end

  i2crb_bridge #(.BUSY_CYCLES(BUSY)) u_dut (
    .ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .test_strap_i(test_strap),
    .output_format_strap_i(fmt_strap), .addr_strap_i(addr_strap), .mem_req_o(mem_req),
    .reg_rdata_i(regs[mem_req.addr[7:0]]), .ee_rdata_i(ee[mem_req.addr[7:0]]), .bank_select_o(bank),
    .ee_busy_o(busy), .direct_ee_mode_o(direct), .boot_config_done_o(done), .output_format_strap_o(fmt_q));
  i2crb_master u_master (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  always @(posedge ref_clk_i) begin
    if (mem_req.reg_wr) regs[mem_req.addr[7:0]] <= mem_req.wdata;
    if (mem_req.ee_wr) ee[mem_req.addr[7:0]] <= mem_req.wdata;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] b[$], input logic rep);
    logic [7:0] r;
    logic ack;
    u_master.start();
    u_master.byte_x({SLAVE_ADDR_1, 1'b0}, 1'b1, r, ack);
    chk(ack, 1'b0);
    foreach (b[i]) begin
      u_master.byte_x(b[i], 1'b1, r, ack);
      chk(ack, 1'b0);
    end
    if (!rep) u_master.stop();
  endtask

  task automatic rd(input logic [7:0] exp[$]);
    logic [7:0] r;
    logic ack;
    u_master.start();
    u_master.byte_x({SLAVE_ADDR_1, 1'b1}, 1'b1, r, ack);
    chk(ack, 1'b0);
    foreach (exp[i]) begin
      u_master.byte_x(8'hFF, i == exp.size() - 1, r, ack);
      chk(r, exp[i]);
    end
    u_master.stop();
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    // the tests take about 102k core cycles
    repeat (130000) @(posedge ref_clk_i);
    fails++;
    stop_test();
  end

  initial begin
    logic [7:0] r;
    logic ack;
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'hA5;
      ee[i] = 8'(i) ^ 8'h3C;
    end
    repeat (10) @(negedge ref_clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(negedge ref_clk_i);
    repeat (40) @(negedge ref_clk_i);
    chk(done, 1'b1);
    chk(fmt_q, 2'h1);
    chk(direct, 1'b0);
    wr('{CMD_WRITE, 8'h00, 8'h10, 8'h11, 8'h22}, 1'b0);
    chk(regs[8'h10], 8'h11);
    chk(regs[8'h11], 8'h22);
    wr('{CMD_READ, 8'h00, 8'h10}, 1'b1);
    rd('{8'h11, 8'h22});
    wr('{CMD_READ, 8'h00, 8'h20}, 1'b0);
    u_master.start();
    u_master.byte_x({SLAVE_ADDR_2, 1'b0}, 1'b1, r, ack);
    chk(ack, 1'b1);
    u_master.stop();
    rd('{8'h20 ^ 8'hA5, 8'h20 ^ 8'hA5});
    wr('{CMD_WRITE, 8'h00, 8'h00, 8'h01}, 1'b0);
    chk(bank, 1'b1);
    wr('{CMD_WREN}, 1'b0);
    wr('{CMD_WRITE, 8'h00, 8'h3F, 8'hAA, 8'hBB}, 1'b0);
    chk(ee[8'h3F], 8'hAA);
    chk(ee[8'h20], 8'hBB);
    chk(busy, 1'b1);
    wr('{CMD_RDSR}, 1'b0);
    rd('{8'h01});
    wr('{CMD_RDSR}, 1'b0);
    rd('{8'h00});
    // pins move: soft reset must keep the value latched at the pin reset
    fmt_strap = 2'h2;
    soft_reset_i = 1'b1;
    @(negedge ref_clk_i);
    soft_reset_i = 1'b0;
    @(negedge ref_clk_i);
    chk(bank, 1'b0);
    chk(fmt_q, 2'h1);
    chk(done, 1'b1);
    test_strap = 1'b1;
    fmt_strap = 2'h0;
    reset_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    chk(direct, 1'b1);
    chk(fmt_q, 2'h0);
    test_strap = 1'b0;
    reset_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    chk(direct, 1'b0);
    stop_test();
  end
endmodule
